// ---- pkg/remcx_pkg.sv ----
package remcx_pkg;
  // Word offsets of the command and response frames.
  localparam logic [3:0] REMCX_OFS_CODE = 4'h0c;
  localparam logic [3:0] REMCX_OFS_ADDR = 4'h0d;
  localparam logic [3:0] REMCX_OFS_LOW = 4'h0e;
  localparam logic [3:0] REMCX_OFS_HIGH = 4'h0f;
  // Field position and widths.
  localparam int REMCX_ERR_BIT = 15;
  localparam int REMCX_CODE_W = 12;
  localparam int REMCX_ADDR_W = 8;
  // Target addresses.
  localparam logic [7:0] REMCX_ADDR_SELF = 8'h80;
  localparam logic [7:0] REMCX_ADDR_MAX = 8'h0b;
  // Communication error codes.
  localparam logic [7:0] REMCX_ERR_NONE = 8'h00;
  localparam logic [7:0] REMCX_ERR_LINK = 8'h84;
  localparam logic [7:0] REMCX_ERR_TIMEOUT = 8'h85;
  localparam logic [7:0] REMCX_ERR_UNDEF = 8'h88;
  localparam logic [7:0] REMCX_ERR_UIF = 8'h89;
  localparam logic [7:0] REMCX_ERR_NVM = 8'h8a;
  localparam logic [7:0] REMCX_ERR_RANGE = 8'h8c;
  localparam logic [7:0] REMCX_ERR_SLAVE = 8'h8d;
  localparam logic [7:0] REMCX_ERR_RESET = 8'h00;
  localparam logic [15:0] REMCX_WORD_RESET = 16'h0000;
  // Command classes reported by the code decoder.
  typedef enum logic [1:0] {
    REMCX_CLS_UNDEF = 2'b00,
    REMCX_CLS_READ = 2'b01,
    REMCX_CLS_WRITE = 2'b10,
    REMCX_CLS_MAINT = 2'b11
  } remcx_cls_t;
  // Handshake states.
  typedef enum logic [1:0] {
    REMCX_IDLE = 2'b00,
    REMCX_EXEC = 2'b01,
    REMCX_DONE = 2'b10,
    REMCX_FAIL = 2'b11
  } remcx_state_t;
endpackage : remcx_pkg

// ---- test/remcx_exec_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// Executor stand-in that answers each job after a latency set by the bench.
module remcx_exec_model #(
  parameter logic [31:0] RES = 32'h5a3c_0ff1
) (
  input wire logic clk,
  input wire logic job_start,
  input wire logic [3:0] lat,
  output logic job_done,
  output logic [31:0] job_result
);
  int cnt = 0;
  // A latency of zero answers on the edge right after the start pulse is seen.
  always @(posedge clk) begin
    job_done <= (cnt == 1);
    if (job_start) begin
      cnt <= int'(lat) + 1;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
  // Outside the done pulse the bus shows the inverse, so a late sample is caught.
  assign job_result = job_done ? RES : ~RES;
endmodule : remcx_exec_model
`default_nettype wire

// ---- test/tb.sv ----
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("[FAIL] %s exp %h got %h", nm, (ex), (got)); end end
module tb;
  import remcx_pkg::*;
  localparam logic [31:0] RES = 32'h5a3c_0ff1;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic exec_request = 1'b0;
  logic uif_busy = 1'b0, nvm_busy = 1'b0, range_ok = 1'b1;
  logic fault_link = 1'b0, fault_timeout = 1'b0, fault_slave = 1'b0;
  logic [1:0] code_class = 2'b01;
  logic [3:0] lat = 4'h1;
  logic [15:0] code_w = 16'h0000, addr_w = 16'h0000, low_w = 16'h0000, high_w = 16'h0000;
  logic [15:0] rsp_code, rsp_addr, rsp_low, rsp_high;
  logic [31:0] job_value, job_result;
  logic job_start, job_done, internal_busy, cmd_complete, reg_error;
  logic [7:0] comm_error_code;
  int check_count = 0;
  int n_mismatch = 0;
  always #2 clk = ~clk;
  // Slave 3 has its connection disabled for the refusal case.
  remcx_top dut_u (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .master_to_device_words_code(code_w), .master_to_device_words_addr(addr_w),
    .master_to_device_words_low(low_w), .master_to_device_words_high(high_w),
    .exec_request(exec_request), .uif_busy(uif_busy), .nvm_busy(nvm_busy),
    .conn_enable(12'hff7), .code_class(code_class), .code_local(1'b0), .range_ok(range_ok),
    .job_code(), .job_addr(), .job_value(job_value), .job_start(job_start),
    .job_done(job_done), .job_result(job_result), .fault_link(fault_link),
    .fault_timeout(fault_timeout), .fault_slave(fault_slave),
    .device_to_master_words_code(rsp_code), .device_to_master_words_addr(rsp_addr),
    .device_to_master_words_low(rsp_low), .device_to_master_words_high(rsp_high),
    .internal_busy(internal_busy), .cmd_complete(cmd_complete), .reg_error(reg_error),
    .comm_error_code(comm_error_code));
  remcx_exec_model #(.RES(RES)) exec_u (.clk(clk), .job_start(job_start), .lat(lat),
    .job_done(job_done), .job_result(job_result));
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  // One full handshake; env is {uif, nvm, range bad, link, timeout, slave error}.
  task automatic run(input logic [1:0] cls, input logic [7:0] ad, input logic [31:0] val,
      input logic [5:0] env, input logic pre, input logic [7:0] ec, input logic [31:0] ed);
    int i;
    logic err;
    logic [15:0] ecw;
    err = (ec != 8'h00);
    ecw = {err, 3'b000, 12'h0a0 | {10'h000, cls}};
    @(posedge clk);
    code_w <= 16'h00a0 | {14'h0000, cls};
    addr_w <= {8'h00, ad};
    {high_w, low_w} <= val;
    code_class <= cls;
    {uif_busy, nvm_busy, range_ok, fault_link, fault_timeout, fault_slave} <= env ^ 6'h08;
    lat <= lat + 4'h3;
    exec_request <= 1'b1;
    @(posedge clk);
    #1;
    `CHK("busy", pre, internal_busy)
    `CHK("start", pre, job_start)
    if (pre) `CHK("value", (cls == 2'b01) ? 32'h0000_0000 : val, job_value)
    for (i = 0; i < 40 && cmd_complete !== 1'b1 && reg_error !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    if (i == 40) begin
      n_mismatch++;
      results();
    end
    `CHK("cplt", !err, cmd_complete)
    `CHK("rerr", err, reg_error)
    `CHK("bsy_end", 1'b0, internal_busy)
    `CHK("rsp_code", ecw, rsp_code)
    `CHK("rsp_addr", {8'h00, ad}, rsp_addr)
    if (!err) `CHK("rsp_data", ed, {rsp_high, rsp_low})
    `CHK("ecode", ec, comm_error_code)
    repeat (3) @(posedge clk);
    #1;
    `CHK("held", {1'b0, !err}, {internal_busy, cmd_complete})
    @(posedge clk);
    exec_request <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    `CHK("drop", {2'b00, ec}, {cmd_complete, reg_error, comm_error_code})
    $display("test code %h addr %h done", ecw, ad);
  endtask : run
  // Good commands follow each run of refusals and faults so the sticky code is seen to clear.
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    run(2'b01, 8'h05, 32'hdead_beef, 6'h00, 1'b1, 8'h00, RES);
    run(2'b00, 8'h05, 32'h0000_0000, 6'h00, 1'b0, 8'h88, RES);
    run(2'b10, 8'h80, 32'h0001_0002, 6'h00, 1'b1, 8'h00, 32'h0001_0002);
    run(2'b10, 8'h80, 32'h0000_0007, 6'h20, 1'b0, 8'h89, RES);
    run(2'b11, 8'h80, 32'h0000_0001, 6'h10, 1'b0, 8'h8a, RES);
    run(2'b01, 8'h03, 32'h0000_0000, 6'h00, 1'b0, 8'h85, RES);
    run(2'b01, 8'h0c, 32'h0000_0000, 6'h00, 1'b0, 8'h85, RES);
    run(2'b10, 8'h05, 32'hffff_0000, 6'h08, 1'b0, 8'h8c, RES);
    run(2'b11, 8'h80, 32'h0000_0001, 6'h00, 1'b1, 8'h00, 32'h0000_0001);
    run(2'b01, 8'h0b, 32'h0000_0000, 6'h04, 1'b1, 8'h84, RES);
    run(2'b01, 8'h00, 32'h0000_0000, 6'h02, 1'b1, 8'h85, RES);
    run(2'b10, 8'h05, 32'h0000_0005, 6'h01, 1'b1, 8'h8d, RES);
    run(2'b01, 8'h05, 32'h1234_5678, 6'h00, 1'b1, 8'h00, RES);
    // A request raised while frozen must not start anything.
    @(posedge clk);
    clk_en <= 1'b0;
    exec_request <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    `CHK("frozen", 3'b000, {internal_busy, cmd_complete, reg_error})
    @(posedge clk);
    clk_en <= 1'b1;
    exec_request <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    `CHK("thawed", 3'b000, {internal_busy, cmd_complete, reg_error})
    $display("test freeze done");
    results();
  end
endmodule : tb
`default_nettype wire

// ---- verilog/remcx_top.sv ----
// How it works
// - A read command ignores the setting value words.
// - Execution starts on the request bit with the frame held valid.
// - Command code and target address are echoed in response words one and two.
// - A read returns its 32-bit result in the two data words.
// - Write and maintenance commands echo the setting value in the data words.
// - Response bit 15 is 0 on success and 1 on error.
// - Busy stays high while a command executes.
// - Completion rises on proper completion.
// - Completion falls when the request drops.
// - A refused command is skipped; any failing command flags error and records an error code.
// - On error busy falls, register error rises, completion stays low.
// - Register error clears when the request drops.
// - Error code is kept and cleared to 00h by a later good command.
// - Link fault, check character or header error records 84h.
// - Slave timeout or disabled connection records 85h.
// - Undefined command records 88h and is refused.
// - Busy user-interface port records 89h and refuses.
// - Non-volatile memory activity records 8Ah and refuses.
// - Out-of-range data records 8Ch; slave error reply records 8Dh.
`timescale 1ns/1ns
`default_nettype none
module remcx_top (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [15:0] master_to_device_words_code,
  input wire logic [15:0] master_to_device_words_addr,
  input wire logic [15:0] master_to_device_words_low,
  input wire logic [15:0] master_to_device_words_high,
  input wire logic exec_request,
  input wire logic uif_busy,
  input wire logic nvm_busy,
  input wire logic [11:0] conn_enable,
  input wire logic [1:0] code_class,
  input wire logic code_local,
  input wire logic range_ok,
  output logic [11:0] job_code,
  output logic [7:0] job_addr,
  output logic [31:0] job_value,
  output logic job_start,
  input wire logic job_done,
  input wire logic [31:0] job_result,
  input wire logic fault_link,
  input wire logic fault_timeout,
  input wire logic fault_slave,
  output logic [15:0] device_to_master_words_code,
  output logic [15:0] device_to_master_words_addr,
  output logic [15:0] device_to_master_words_low,
  output logic [15:0] device_to_master_words_high,
  output logic internal_busy,
  output logic cmd_complete,
  output logic reg_error,
  output logic [7:0] comm_error_code
);
  import remcx_pkg::*;

  typedef struct packed {
    remcx_state_t st;
    logic req_d;
    remcx_cls_t cls;
    logic [11:0] code;
    logic [7:0] addr;
    logic [31:0] value;
    logic start;
    logic [15:0] r_code;
    logic [15:0] r_addr;
    logic [15:0] r_low;
    logic [15:0] r_high;
    logic busy;
    logic done;
    logic rerr;
    logic [7:0] ecode;
  } remcx_s_t;

  remcx_s_t s_reg;
  remcx_s_t s_next;

  // Pre-check of a request; returns the refusing error code or 00h.
  function automatic logic [7:0] remcx_precheck(input logic [1:0] cls, input logic [7:0] addr,
      input logic [11:0] en, input logic uif, input logic nvm, input logic rng);
    logic [7:0] r;
    r = REMCX_ERR_NONE;
    if (cls == REMCX_CLS_UNDEF) begin
      r = REMCX_ERR_UNDEF;
    end else if (uif) begin
      r = REMCX_ERR_UIF;
    end else if (nvm) begin
      r = REMCX_ERR_NVM;
    end else if (addr != REMCX_ADDR_SELF && (addr > REMCX_ADDR_MAX || !en[addr[3:0]])) begin
      r = REMCX_ERR_TIMEOUT;
    end else if (cls != REMCX_CLS_READ && !rng) begin
      r = REMCX_ERR_RANGE;
    end
    return r;
  endfunction : remcx_precheck

  logic req_rise;
  logic [7:0] pre_err;
  logic [7:0] run_err;

  // The request is taken on its rising edge only, so a held request runs once.
  assign req_rise = exec_request && !s_reg.req_d;
  assign pre_err = remcx_precheck(code_class, master_to_device_words_addr[7:0], conn_enable,
                                  uif_busy, nvm_busy, range_ok);
  // Fault priority when the executor reports several at once.
  assign run_err = fault_link ? REMCX_ERR_LINK :
                   fault_timeout ? REMCX_ERR_TIMEOUT :
                   fault_slave ? REMCX_ERR_SLAVE : REMCX_ERR_NONE;

  // Next-state logic of the handshake; the frame is latched at the start edge.
  always_comb begin
    s_next = s_reg;
    s_next.start = 1'b0;
    s_next.req_d = exec_request;
    case (s_reg.st)
      REMCX_IDLE: begin
        if (req_rise) begin
          s_next.code = master_to_device_words_code[REMCX_CODE_W-1:0];
          s_next.addr = master_to_device_words_addr[REMCX_ADDR_W-1:0];
          s_next.cls = remcx_cls_t'(code_class);
          // A read carries no setting value, so zero is latched and the executor never sees it.
          s_next.value = (code_class == REMCX_CLS_READ) ? 32'h0000_0000 :
                         {master_to_device_words_high, master_to_device_words_low};
          s_next.r_code = {4'h0, master_to_device_words_code[REMCX_CODE_W-1:0]};
          s_next.r_addr = {8'h00, master_to_device_words_addr[REMCX_ADDR_W-1:0]};
          if (pre_err != REMCX_ERR_NONE) begin
            // Refused without execution; busy never rises.
            s_next.st = REMCX_FAIL;
            s_next.r_code[REMCX_ERR_BIT] = 1'b1;
            s_next.ecode = pre_err;
            s_next.rerr = 1'b1;
          end else begin
            s_next.st = REMCX_EXEC;
            s_next.busy = 1'b1;
            s_next.start = 1'b1;
          end
        end
      end
      REMCX_EXEC: begin
        // A request dropped mid-command does not abort the executor.
        if (job_done) begin
          s_next.busy = 1'b0;
          if (run_err != REMCX_ERR_NONE) begin
            s_next.st = REMCX_FAIL;
            s_next.r_code[REMCX_ERR_BIT] = 1'b1;
            s_next.ecode = run_err;
            s_next.rerr = 1'b1;
          end else begin
            s_next.st = REMCX_DONE;
            s_next.r_code[REMCX_ERR_BIT] = 1'b0;
            s_next.ecode = REMCX_ERR_NONE;
            s_next.done = 1'b1;
            if (s_reg.cls == REMCX_CLS_READ) begin
              s_next.r_low = job_result[15:0];
              s_next.r_high = job_result[31:16];
            end else begin
              s_next.r_low = s_reg.value[15:0];
              s_next.r_high = s_reg.value[31:16];
            end
          end
        end
      end
      REMCX_DONE: begin
        if (!exec_request) begin
          s_next.done = 1'b0;
          s_next.st = REMCX_IDLE;
        end
      end
      REMCX_FAIL: begin
        if (!exec_request) begin
          s_next.rerr = 1'b0;
          s_next.st = REMCX_IDLE;
        end
      end
      default: begin
        s_next.st = REMCX_IDLE;
      end
    endcase
  end

  // State register; the clock enable freezes everything.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_reg <= '0;
      s_reg.st <= REMCX_IDLE;
      s_reg.ecode <= REMCX_ERR_RESET;
      s_reg.req_d <= 1'b1;
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end

  // The read case was zeroed when the frame was latched, so this output is a plain flop.
  assign job_value = s_reg.value;
  assign job_code = s_reg.code;
  assign job_addr = s_reg.addr;
  assign job_start = s_reg.start;
  assign device_to_master_words_code = s_reg.r_code;
  assign device_to_master_words_addr = s_reg.r_addr;
  assign device_to_master_words_low = s_reg.r_low;
  assign device_to_master_words_high = s_reg.r_high;
  assign internal_busy = s_reg.busy;
  assign cmd_complete = s_reg.done;
  assign reg_error = s_reg.rerr;
  assign comm_error_code = s_reg.ecode;

  logic unused_ok;
  assign unused_ok = code_local;

  // Checks of the handshake.
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst || !clk_en);

  busy_on_start_a: assert property (job_start |-> internal_busy)
    else $error("Busy low during start.");
  done_not_err_a: assert property (!(cmd_complete && reg_error))
    else $error("Completion and error together.");
  // A new request may follow one low cycle later, so only the very next edge is checked.
  done_drop_a: assert property (cmd_complete && !exec_request |=> !cmd_complete)
    else $error("Completion stuck.");
  err_clear_a: assert property (reg_error && !exec_request |=> !reg_error)
    else $error("Register error stuck.");
  err_bit_a: assert property (reg_error |-> device_to_master_words_code[15])
    else $error("Error bit missing.");
  ok_bit_a: assert property (cmd_complete |-> !device_to_master_words_code[15])
    else $error("Error bit on success.");
  ok_code_a: assert property (cmd_complete |-> comm_error_code == 8'h00)
    else $error("Error code not cleared.");
  err_busy_a: assert property (reg_error |-> !internal_busy)
    else $error("Busy with error.");
  undef_code_a: assert property (reg_error && !$past(reg_error) && !$past(internal_busy)
      && $past(code_class) == 2'b00 |-> comm_error_code == 8'h88)
    else $error("Undefined command code wrong.");


  // Start pulse and busy window of an accepted command.
  // The executor relies on a single start pulse per command.
  start_pulse_a: assert property (job_start |=> !job_start)
    else $error("Start pulse too long.");
  busy_rise_a: assert property ($rose(internal_busy) |-> job_start)
    else $error("Busy rose without start.");
  start_idle_a: assert property (job_start |-> $past(s_reg.st) == REMCX_IDLE)
    else $error("Start outside idle.");
  start_edge_a: assert property (job_start |-> $past(exec_request) && !$past(s_reg.req_d))
    else $error("Start without request edge.");
  busy_hold_a: assert property (internal_busy && !job_done |=> internal_busy)
    else $error("Busy dropped early.");
  busy_fall_a: assert property (internal_busy && job_done |=> !internal_busy)
    else $error("Busy stuck after done.");
  done_no_busy_a: assert property (cmd_complete |-> !internal_busy)
    else $error("Busy with completion.");

  // Echo of the frame header, checked against the words seen at the taking edge.
  echo_code_a: assert property ($rose(internal_busy) |->
      device_to_master_words_code[11:0] == $past(master_to_device_words_code[11:0]))
    else $error("Code echo wrong.");
  echo_addr_a: assert property ($rose(internal_busy) |->
      device_to_master_words_addr == {8'h00, $past(master_to_device_words_addr[7:0])})
    else $error("Address echo wrong.");
  read_zero_a: assert property (job_start && s_reg.cls == REMCX_CLS_READ
      |-> job_value == 32'h0000_0000)
    else $error("Read passed a setting value.");

  // Data words of a clean finish; faults are excluded because they leave the data alone.
  read_data_a: assert property (internal_busy && job_done && !fault_link && !fault_timeout
      && !fault_slave && s_reg.cls == REMCX_CLS_READ
      |=> {device_to_master_words_high, device_to_master_words_low} == $past(job_result))
    else $error("Read result not returned.");
  write_data_a: assert property (internal_busy && job_done && !fault_link && !fault_timeout
      && !fault_slave && s_reg.cls != REMCX_CLS_READ
      |=> {device_to_master_words_high, device_to_master_words_low} == $past(job_value))
    else $error("Setting value not echoed.");

  // Executor faults and their codes, in priority order.
  link_code_a: assert property (internal_busy && job_done && fault_link
      |=> comm_error_code == 8'h84 && reg_error)
    else $error("Link fault code wrong.");
  tmo_code_a: assert property (internal_busy && job_done && !fault_link && fault_timeout
      |=> comm_error_code == 8'h85 && reg_error)
    else $error("Timeout code wrong.");
  slave_code_a: assert property (internal_busy && job_done && !fault_link && !fault_timeout
      && fault_slave |=> comm_error_code == 8'h8d && reg_error)
    else $error("Slave error code wrong.");

  // The stored code may only move together with a result flag.
  code_hold_a: assert property ($changed(comm_error_code) |-> reg_error || cmd_complete)
    else $error("Error code changed alone.");
  fail_no_done_a: assert property ($rose(reg_error) |-> !cmd_complete && !internal_busy)
    else $error("Error raised with completion or busy.");

  cov_refuse_c: cover property ($rose(reg_error) && !$past(internal_busy));
  cov_fault_c: cover property ($fell(internal_busy) && reg_error);
  cov_ok_c: cover property ($rose(cmd_complete));
  cov_err_c: cover property ($rose(reg_error));
  cov_read_c: cover property (cmd_complete && s_reg.cls == REMCX_CLS_READ);
endmodule : remcx_top
`default_nettype wire
